// file: bench/fpo_seq_tb.sv
// self-checking bench for the protection override command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fpo_consts.svh"
module fpo_seq_tb import fpo_pkg::*;;
  localparam logic [15:0] KEY = 16'h5A3C; // key held in the configuration area
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic launch = 1'b0; // software clearing the complete flag
  logic allowed = 1'b1;
  logic addr_ok = 1'b1;
  logic ee_prot = 1'b0;
  logic vdone = 1'b0;
  logic rerr = 1'b0;
  logic runc = 1'b0;
  logic pwr = 1'b0; // direct protection register write
  logic [2:0] idx = 3'h0;
  logic [63:0] words = 64'h0;
  fpo_prot_t pwd = 16'h0;
  logic [15:0] skey = KEY; // stored key as the configuration area shows it
  int n_ego = 0; // cycles seen with erase in progress
  logic ego, vgo, ov;
  logic [23:0] eaddr;
  fpo_stat_t st;
  fpo_prot_t prot;
  int n_fail = 0;
  int n_tests = 0;
  // short erase step keeps the run brief
  fpo_seq #(.STEP_CYC(2)) u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_launch(launch),
    .i_param_word_index(idx), .i_cmd_param_words(words), .i_cmd_allowed(allowed),
    .i_addr_valid(addr_ok), .i_ee_protected(ee_prot), .i_stored_key(skey),
    .i_verify_done(vdone), .i_read_err(rerr), .i_read_uncorr(runc), .i_prot_wr(pwr),
    .i_prot_wdata(pwd), .o_erase_go(ego), .o_verify_go(vgo), .o_erase_addr(eaddr),
    .o_cmd_status_reg(st), .o_override_active_bit(ov), .o_prot(prot));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // single exit point for pass, fail and watchdog
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // status flags followed by the override active bit
  task automatic chk_stat(input string what, input logic [5:0] exp);
    n_tests++;
    if ({st, ov} !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, {st, ov});
    end
  endtask
  // register values and addresses
  task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // launch one command; answers verify with a one-cycle done pulse, waits bounded
  task automatic run(input logic [2:0] ix, input logic [63:0] w);
    logic sent;
    logic vg;
    sent = 1'b0;
    vg = 1'b0;
    n_ego = 0;
    @(posedge clk);
    launch <= 1'b1;
    idx <= ix;
    words <= w;
    @(posedge clk);
    launch <= 1'b0;
    #1;
    if (ego === 1'b1) n_ego++;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      vdone <= vg;
      sent = sent | vg;
      #1;
      if (ego === 1'b1) n_ego++;
      vg = (vgo === 1'b1) && !sent;
      if (st.cmd_complete_flag === 1'b1) return;
    end
    n_fail++;
    $display("ERROR complete expected 1 seen %b", st.cmd_complete_flag);
  endtask
  task automatic ovr(input logic [2:0] ix, input logic [1:0] sel, input logic [15:0] key,
                     input logic [7:0] p, input logic [7:0] e);
    run(ix, {`FPO_OP_PROT_OVRD, 6'h00, sel, key, 8'h00, p, 8'h00, e});
  endtask
  task automatic ers(input logic [2:0] ix, input logic [23:0] a);
    run(ix, {`FPO_OP_SECT_ERASE, a, 32'h0});
  endtask
  // direct write, then settle
  task automatic pwrite(input logic [15:0] v);
    @(posedge clk);
    pwr <= 1'b1;
    pwd <= v;
    @(posedge clk);
    pwr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk_stat("reset status", 6'b100000);
    chk_val("reset prot", 24'h00FFFF, 24'(prot));
    $display("test reset done");
  endtask
  // restore asked for with no backup in place
  task automatic t_no_backup();
    ovr(3'h1, 2'b11, 16'h1234, 8'h00, 8'h00);
    chk_stat("no backup", 6'b110000);
    chk_val("no backup prot", 24'h00FFFF, 24'(prot));
    $display("test no_backup done");
  endtask
  task automatic t_override();
    ovr(3'h3, 2'b01, KEY, 8'h3C, 8'h77);
    chk_stat("ovr1", 6'b100001);
    chk_val("ovr1 prot", 24'h003CFF, 24'(prot));
    pwrite(16'h8142);
    ovr(3'h3, 2'b10, KEY, 8'h00, 8'h55);
    chk_val("ovr2 prot", 24'h008155, 24'(prot));
    // this write must vanish on restore
    pwrite(16'hAABB);
    ovr(3'h1, 2'b00, `FPO_KEY_ERASED, 8'h00, 8'h00);
    chk_stat("invalid key", 6'b100000);
    chk_val("restore prot", 24'h008142, 24'(prot));
    ovr(3'h2, 2'b11, KEY, 8'h11, 8'h22);
    chk_val("ovr3 prot", 24'h001122, 24'(prot));
    ovr(3'h1, 2'b11, 16'h1234, 8'h00, 8'h00);
    chk_stat("mismatch", 6'b100000);
    chk_val("mismatch prot", 24'h008142, 24'(prot));
    $display("test override done");
  endtask
  // bad index, empty selection, unavailable mode
  task automatic t_launch_err();
    logic [2:0] ixs [5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3};
    logic [1:0] sels [5] = '{2'b01, 2'b01, 2'b00, 2'b00, 2'b01};
    for (int i = 0; i < 5; i++) begin
      allowed <= (i != 4);
      ovr(ixs[i], sels[i], KEY, 8'h00, 8'h00);
      chk_stat("launch error", 6'b110000);
      chk_val("launch error prot", 24'h008142, 24'(prot));
    end
    allowed <= 1'b1;
    // erased stored key: even the right key only asks for a restore
    skey <= `FPO_KEY_ERASED;
    ovr(3'h3, 2'b01, KEY, 8'h00, 8'h00);
    chk_stat("erased stored key", 6'b110000);
    chk_val("erased key prot", 24'h008142, 24'(prot));
    skey <= KEY;
    $display("test launch_err done");
  endtask
  task automatic t_erase();
    ers(3'h2, 24'h100000);
    chk_stat("erase index", 6'b110000);
    chk_val("erase go refused", 24'd0, 24'(n_ego));
    ers(3'h1, 24'h100001);
    chk_stat("erase odd", 6'b110000);
    addr_ok <= 1'b0;
    ers(3'h1, 24'h100000);
    chk_stat("erase addr", 6'b110000);
    addr_ok <= 1'b1;
    ee_prot <= 1'b1;
    ers(3'h1, 24'h100000);
    chk_stat("erase protected", 6'b101000);
    ee_prot <= 1'b0;
    rerr <= 1'b1;
    ers(3'h1, 24'h10ABCE);
    chk_stat("erase read err", 6'b100100);
    chk_val("erase addr", 24'h10ABCE, eaddr);
    chk_val("erase go cycles", 24'd2, 24'(n_ego));
    runc <= 1'b1;
    ers(3'h1, 24'h10ABCE);
    chk_stat("erase uncorr", 6'b100110);
    $display("test erase done");
  endtask
  // reset held three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_no_backup();
    t_override();
    t_launch_err();
    t_erase();
    finish_test();
  end
  // all scenarios need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule // fpo_seq_tb
`default_nettype wire

// file: design/fpo_consts.svh
// constants for the flash protection override command sequencer
`ifndef FPO_CONSTS_SVH
`define FPO_CONSTS_SVH
`define FPO_OP_SECT_ERASE 8'h12
`define FPO_OP_PROT_OVRD 8'h13
`define FPO_IDX_1 3'h1
`define FPO_IDX_2 3'h2
`define FPO_IDX_3 3'h3
`define FPO_KEY_ERASED 16'hFFFF
`define FPO_SEL_PROG 0
`define FPO_SEL_EE 1
`define FPO_PROT_RST 8'hFF
`define FPO_STEP_NS 1000
`define FPO_CLK_NS 25
`define FPO_STEP_CYC ((`FPO_STEP_NS + `FPO_CLK_NS - 1) / `FPO_CLK_NS)
`endif

// file: design/fpo_pkg.sv
// types for the flash protection override command sequencer
`default_nettype none
package fpo_pkg;
  // status flags of the command status register
  typedef struct packed {
    logic cmd_complete_flag;
    logic access_error_flag;
    logic protect_violation_flag;
    logic margin_status_hi;
    logic margin_status_lo;
  } fpo_stat_t;
  // protection register pair
  typedef struct packed {
    logic [7:0] prog;
    logic [7:0] ee;
  } fpo_prot_t;
  // sequencer states
  typedef enum logic [2:0] {
    FPO_IDLE,
    FPO_ERASE,
    FPO_VERIFY,
    FPO_DONE
  } fpo_state_t;
endpackage
`default_nettype wire

// file: design/fpo_seq.sv
// command sequencer: eeprom sector erase and protection override
`timescale 1ns/1ps
`default_nettype none
`include "fpo_consts.svh"

// Overview of operation
// [RULE1] launch erases sector, verifies, sets complete
// [RULE2] erase index not 001 sets access error
// [RULE3] invalid or odd address sets access error
// [RULE4] protected eeprom area sets protection violation
// [RULE5] any verify read error sets margin hi
// [RULE6] uncorrectable verify error sets margin lo
// [RULE7] software loads opcode, key, two values
// [RULE8] selection bits choose registers to replace
// [RULE9] key ffff invalid, disables override
// [RULE10] key match backs up, then overwrites selected
// [RULE11] success sets override active bit
// [RULE12] mismatch or invalid key restores, clears active
// [RULE13] erased stored key disables feature permanently
// [RULE14] launch access error leaves protection untouched
// [RULE15] single entry backup overwritten each launch; here only a key-match override launch overwrites it
// [RULE16] direct writes during override lost on restore
// [RULE17] restore loads backup, never reset values
// [RULE18] override index not 1,2,3 sets error
// [RULE19] restore with override inactive sets error
// [RULE20] selection 00 with index 2,3 errors
// [RULE21] selection 00, index 1, valid key errors
// [RULE22] unavailable in mode sets access error
// [RULE23] override always ends with complete flag set
module fpo_seq import fpo_pkg::*; #(
  parameter int STEP_CYC = `FPO_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_launch,
  input wire logic [2:0] i_param_word_index,
  input wire logic [63:0] i_cmd_param_words,
  input wire logic i_cmd_allowed,
  input wire logic i_addr_valid,
  input wire logic i_ee_protected,
  input wire logic [15:0] i_stored_key,
  input wire logic i_verify_done,
  input wire logic i_read_err,
  input wire logic i_read_uncorr,
  input wire logic i_prot_wr,
  input wire fpo_prot_t i_prot_wdata,
  output logic o_erase_go,
  output logic o_verify_go,
  output logic [23:0] o_erase_addr,
  output fpo_stat_t o_cmd_status_reg,
  output logic o_override_active_bit,
  output fpo_prot_t o_prot
);
  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be at least one");
  end
  // reset synchroniser
  logic rst_s1, rst_s2;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_n = rst_s2;

  // parameter word fields
  logic [7:0] opcode;
  logic [1:0] sel;
  logic [15:0] key;
  logic [23:0] gaddr;
  assign opcode = i_cmd_param_words[63:56];
  assign sel = i_cmd_param_words[49:48];
  assign key = i_cmd_param_words[47:32];
  assign gaddr = {i_cmd_param_words[55:48], i_cmd_param_words[47:32]};

  fpo_state_t state;
  logic [15:0] cnt; // erase step timer
  fpo_prot_t backup; // single-entry backup
  logic start;
  assign start = i_launch && state == FPO_IDLE && o_cmd_status_reg.cmd_complete_flag;

  // erase launch checks
  logic er_acc;
  // [RULE2] [RULE3] [RULE22] erase launch checks
  assign er_acc = !i_cmd_allowed || i_param_word_index != `FPO_IDX_1
    || !i_addr_valid || gaddr[0];

  // override decode
  logic key_inv, key_ok, idx_ok, want_restore, ov_acc;
  // [RULE9] [RULE13] erased key on either side disables
  assign key_inv = key == `FPO_KEY_ERASED || i_stored_key == `FPO_KEY_ERASED;
  assign key_ok = !key_inv && key == i_stored_key;
  // [RULE18] legal index
  assign idx_ok = i_param_word_index == `FPO_IDX_1 || i_param_word_index == `FPO_IDX_2
    || i_param_word_index == `FPO_IDX_3;
  assign want_restore = !key_ok;
  // [RULE19] [RULE20] [RULE21] [RULE22] launch faults
  assign ov_acc = !i_cmd_allowed || !idx_ok
    || (sel == 2'b00 && i_param_word_index != `FPO_IDX_1)
    // an empty selection with a usable supplied key is a launch fault even if the stored key
    // is erased
    || (sel == 2'b00 && key != `FPO_KEY_ERASED)
    || (want_restore && !o_override_active_bit);

  // sequencer state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FPO_IDLE;
      cnt <= 16'h0000;
    end else begin
      unique case (state)
        FPO_IDLE: begin
          // [RULE1] start erase when checks pass
          if (start && opcode == `FPO_OP_SECT_ERASE && !er_acc && !i_ee_protected) begin
            state <= FPO_ERASE;
            cnt <= 16'(STEP_CYC);
          end
        end
        FPO_ERASE: begin
          if (cnt == 16'h0001) state <= FPO_VERIFY;
          cnt <= cnt - 16'h0001;
        end
        FPO_VERIFY: begin
          if (i_verify_done) state <= FPO_DONE;
        end
        FPO_DONE: state <= FPO_IDLE;
        default: state <= FPO_IDLE;
      endcase
    end
  end
  assign o_erase_go = state == FPO_ERASE;
  assign o_verify_go = state == FPO_VERIFY;

  // latched erase address
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_erase_addr <= 24'h000000;
    else if (start) o_erase_addr <= gaddr;
  end

  // status flags; launch clears errors, completion sets complete
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd_status_reg <= '{cmd_complete_flag: 1'b1, default: 1'b0};
    end else if (start) begin
      o_cmd_status_reg <= '0;
      if (opcode == `FPO_OP_SECT_ERASE) begin
        o_cmd_status_reg.access_error_flag <= er_acc;
        // [RULE4] protected area
        o_cmd_status_reg.protect_violation_flag <= !er_acc && i_ee_protected;
        o_cmd_status_reg.cmd_complete_flag <= er_acc || i_ee_protected;
      end else if (opcode == `FPO_OP_PROT_OVRD) begin
        o_cmd_status_reg.access_error_flag <= ov_acc;
        // [RULE23] override finishes in one cycle
        o_cmd_status_reg.cmd_complete_flag <= 1'b1;
      end else begin
        o_cmd_status_reg.cmd_complete_flag <= 1'b1;
      end
    end else begin
      if (state == FPO_VERIFY) begin
        // [RULE5] any read error
        if (i_read_err) o_cmd_status_reg.margin_status_hi <= 1'b1;
        // [RULE6] uncorrectable read error
        if (i_read_uncorr) o_cmd_status_reg.margin_status_lo <= 1'b1;
      end
      // [RULE1] complete after verify
      if (state == FPO_DONE) o_cmd_status_reg.cmd_complete_flag <= 1'b1;
    end
  end

  logic ov_go;
  assign ov_go = start && opcode == `FPO_OP_PROT_OVRD && !ov_acc;

  // protection registers, backup and override bit
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_prot <= '{prog: `FPO_PROT_RST, ee: `FPO_PROT_RST};
      backup <= '{prog: `FPO_PROT_RST, ee: `FPO_PROT_RST};
      o_override_active_bit <= 1'b0;
    end else if (ov_go) begin
      if (key_ok) begin
        // [RULE10] [RULE15] back up, then overwrite selected
        backup <= o_prot;
        // [RULE8] selection bits
        if (sel[`FPO_SEL_PROG]) o_prot.prog <= i_cmd_param_words[23:16];
        if (sel[`FPO_SEL_EE]) o_prot.ee <= i_cmd_param_words[7:0];
        // [RULE11] override active
        o_override_active_bit <= 1'b1;
      end else begin
        // [RULE12] [RULE16] [RULE17] restore from backup
        o_prot <= backup;
        o_override_active_bit <= 1'b0;
      end
    end else if (i_prot_wr) begin
      // [RULE14] errored launches skip the override; a direct write in the same cycle still loads the registers
      o_prot <= i_prot_wdata;
    end
  end

  // [RULE12] restore loads backup exactly
  a_restore_loads: assert property (@(posedge i_clk) disable iff (!rst_n)
    (ov_go && !key_ok) |=> (o_prot == $past(backup) && !o_override_active_bit))
    else $error("restore did not load backup");
  a_match_sets: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE11
    (ov_go && key_ok) |=> o_override_active_bit)
    else $error("override bit not set");
  a_backup_copy: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE10
    (ov_go && key_ok) |=> backup == $past(o_prot))
    else $error("backup not taken");
  a_err_keeps: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE14
    (start && opcode == `FPO_OP_PROT_OVRD && ov_acc && !i_prot_wr) |=> $stable(o_prot))
    else $error("errored override changed protection");
  a_ov_complete: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE23
    (start && opcode == `FPO_OP_PROT_OVRD) |=> o_cmd_status_reg.cmd_complete_flag)
    else $error("override did not complete");
  a_restore_err: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE19
    (start && opcode == `FPO_OP_PROT_OVRD && !key_ok && !o_override_active_bit)
    |=> o_cmd_status_reg.access_error_flag)
    else $error("restore without backup not flagged");
  a_erase_idx: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE2
    (start && opcode == `FPO_OP_SECT_ERASE && i_param_word_index != `FPO_IDX_1)
    |=> o_cmd_status_reg.access_error_flag && o_cmd_status_reg.cmd_complete_flag)
    else $error("bad erase index not flagged");
  a_erase_prot: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE4
    (start && opcode == `FPO_OP_SECT_ERASE && !er_acc && i_ee_protected)
    |=> o_cmd_status_reg.protect_violation_flag && state == FPO_IDLE)
    else $error("protected erase not refused");
  a_erase_flow: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE1
    (state == FPO_VERIFY && i_verify_done) |=> ##1 o_cmd_status_reg.cmd_complete_flag)
    else $error("erase completion not flagged");
endmodule // fpo_seq
`default_nettype wire
